// [hdl/pcr_pkg.sv]
// Shared constants, register map and state types of the packet capture receive path.
package pcr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SNAP   = 8'h04;
  localparam logic [7:0] OFS_MINLEN = 8'h08;
  localparam logic [7:0] OFS_MAXLEN = 8'h0C;
  localparam logic [7:0] OFS_MEMCFG = 8'h10;
  localparam logic [7:0] OFS_DROP   = 8'h14;
  localparam logic [7:0] OFS_ALLOC  = 8'h18;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_W      = 17;
  localparam int B_CAPTURE   = 0;
  localparam int B_VARLEN    = 1;
  localparam int B_WIDEALIGN = 2;
  localparam int B_CRCSEL    = 3;   // Two bits: 3 and 4.
  localparam int B_STRIP     = 5;
  localparam int B_DISCARD   = 6;
  localparam int B_DECOUPLE  = 7;
  localparam int B_EQL       = 8;
  localparam int B_FCL       = 9;
  localparam int B_MASTER    = 10;
  localparam int B_FRAMESCR  = 11;
  localparam int B_PAYSCR    = 12;
  localparam int B_ATM       = 13;
  localparam int B_OC48      = 14;
  localparam int B_LASER     = 15;
  localparam int B_RXTX      = 16;
  localparam int B_SOFTRST   = 17;  // Self-clearing command, not stored.
  localparam int B_MEMTX     = 16;  // Transmit stream count in the memory register.

  localparam logic [1:0] CRC_NONE = 2'h0;
  localparam logic [1:0] CRC_16   = 2'h1;
  localparam logic [1:0] CRC_32   = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h01C16;  // varlen, wide, crc32, scramblers, master; loopbacks off.
  localparam logic [11:0] SNAP_RST   = 12'h030;        // 48 bytes.
  localparam logic [15:0] MINLEN_RST = 16'h0010;
  localparam logic [15:0] MAXLEN_RST = 16'h0600;
  localparam logic [15:0] MEMTOT_RST = 16'h0080;       // Megabytes.
  localparam logic [15:0] TX_STREAM_MB = 16'h0010;
  localparam logic [12:0] HDR_BYTES  = 13'h0008;
  localparam logic [15:0] CRC16_BYTES = 16'h0002;
  localparam logic [15:0] CRC32_BYTES = 16'h0004;
  localparam int RX_STREAMS_LOG2 = 1;

  typedef enum logic [1:0] {ST_IDLE, ST_CAP, ST_EMIT} pcr_state_e;

  typedef struct packed {
    pcr_state_e        st;
    logic [CTRL_W-1:0] ctrl;
    logic [11:0]       snap;
    logic [15:0]       min_len;
    logic [15:0]       max_len;
    logic [15:0]       mem_total;
    logic [1:0]        tx_streams;
    logic [15:0]       drop_cnt;
    logic [7:0]        bus_addr;
    logic              rd_pend;
    logic              wr_pend;
    logic              hready;
    logic [31:0]       hrdata;
    logic [2:0]        clk_s;
    logic [2:0]        frm_s;
    logic [2:0]        ref_s;
    logic [2:0][7:0]   dat_s;
    logic              clk_st;
    logic              frm_st;
    logic              ref_st;
    logic [15:0]       wlen;
    logic [15:0]       rec_wlen;
    logic [11:0]       dlen;
    logic [12:0]       rlen;
    logic [12:0]       bcnt;
    logic [1:0]        err;
    logic              tgt;
    logic              rec_valid;
    logic              rec_last;
    logic              rec_stream;
    logic [7:0]        rec_data;
    logic              txh_full;
    logic [7:0]        txh;
    logic              line_tx_valid;
    logic [7:0]        line_tx_data;
    logic              loop_valid;
    logic [7:0]        loop_data;
  } pcr_state_s;

  localparam pcr_state_s ST_RST = '{st: ST_IDLE, ctrl: CTRL_RST, snap: SNAP_RST, min_len: MINLEN_RST,
                                    max_len: MAXLEN_RST, mem_total: MEMTOT_RST, hready: 1'b1, default: '0};

endpackage

// [hdl/pcr_rx_path.sv]
// Receive capture path: line sampling, snap/pad record builder, stream steering, loopbacks, AHB registers.
//
// Functional notes
// R1: Software programs snap length as multiple of 8, from 48 to 4088.
// R2: Snap length resets to 48 bytes.
// R3: Record header is extra; snap length counts only packet bytes.
// R4: Variable-length capture always uses wide record alignment.
// R5: Records pad to 8-byte alignment when wide, 4-byte otherwise.
// R6: Frame check selectable: none, 16-bit or 32-bit.
// R7: Check-sequence removal drops CRC bytes from record and wire length.
// R8: CRC discard drops CRC bytes from record; ignored without checking.
// R9: Packets above maximum length are flagged yet delivered.
// R10: Packets below minimum length are flagged yet delivered.
// R11: Decoupled streams: a busy stream drops its own records only.
// R12: Coupled streams advance together; drops happen at the receive port.
// R13: Host loopback returns host transmit data to the host.
// R14: Line loopback retransmits received data and still captures it.
// R15: Transmit paced by recovered clock (slave) or reference clock (master).
// R16: Framer scrambling has its own enable.
// R17: Payload scrambling has a separate enable.
// R18: Framer mode: ATM cells or packet-over-SONET, plus OC48 receive.
// R19: Reset command clears drop counter and logic, keeps configuration.
// R20: Combined mode gives 16 MB per transmit stream, rest to receive.
// R21: Stream allocation must not change during capture.
// R22: Laser output follows its control setting.
// R23: Packets longer than snap are truncated; varlen keeps shorter sizes.
// R24: Fixed mode pads shorter packets up to snap length.
// R25: Drop counter counts discarded packets and saturates.
`timescale 1ns/1ps
`default_nettype none

module pcr_rx_path
  import pcr_pkg::*;
#(
  parameter int MEM_DEPTH = 4096
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        line_clk,
  input  wire logic        line_frame,
  input  wire logic [7:0]  line_data,
  input  wire logic        ref_clk,
  output logic             line_tx_valid,
  output logic [7:0]       line_tx_data,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  output logic             loop_valid,
  output logic [7:0]       loop_data,
  input  wire logic [1:0]  stream_ready,
  output logic             rec_valid,
  output logic [7:0]       rec_data,
  output logic             rec_last,
  output logic             rec_stream,
  output logic             laser_en,
  output logic             frame_scramble_en,
  output logic             payload_scramble_en,
  output logic             framer_atm,
  output logic             framer_oc48,
  output logic [1:0]       crc_mode
);

  pcr_state_s s;
  pcr_state_s n;
  logic [7:0] cap_mem [0:MEM_DEPTH-1];
  logic       mem_we;
  logic [11:0] mem_wa;
  logic       lclk_rise;
  logic       ref_rise;
  logic       frm;
  logic       frm_rise;
  logic       frm_fall;
  logic       soft_rst;
  logic       ready_ok;
  logic [15:0] crc_n;
  logic [15:0] cut_rec;
  logic [15:0] cut_wlen;
  logic [15:0] body_raw;
  logic [12:0] body;
  logic [12:0] total;
  logic       wide;
  logic [15:0] rx_alloc;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One process computes every next value; the synchronisers shift in first.
  always_comb
  begin
    n = s;
    n.line_tx_valid = 1'b0;
    n.loop_valid = 1'b0;
    n.wr_pend = 1'b0;
    mem_we = 1'b0;
    mem_wa = s.wlen[11:0];

    // Pins from the line pass three flops; a level counts once stages two and three agree.
    n.clk_s = {s.clk_s[1:0], line_clk};
    n.frm_s = {s.frm_s[1:0], line_frame};
    n.ref_s = {s.ref_s[1:0], ref_clk};
    n.dat_s = {s.dat_s[1:0], line_data};
    if (s.clk_s[1] == s.clk_s[2]) n.clk_st = s.clk_s[2];
    if (s.ref_s[1] == s.ref_s[2]) n.ref_st = s.ref_s[2];
    if (s.frm_s[1] == s.frm_s[2]) n.frm_st = s.frm_s[2];
    lclk_rise = n.clk_st && !s.clk_st;
    ref_rise = n.ref_st && !s.ref_st;
    frm = n.frm_st;
    frm_rise = frm && !s.frm_st;
    frm_fall = !frm && s.frm_st;

    // CRC length in force; ATM cells and a disabled check carry none.
    crc_n = 16'h0000;
    if (!s.ctrl[B_ATM] && s.ctrl[B_CRCSEL+:2] == CRC_16) crc_n = CRC16_BYTES; // [R6]
    if (!s.ctrl[B_ATM] && s.ctrl[B_CRCSEL+:2] == CRC_32) crc_n = CRC32_BYTES; // [R6]
    cut_rec = (s.ctrl[B_STRIP] || s.ctrl[B_DISCARD]) ? crc_n : 16'h0000; // [R7] [R8]
    cut_wlen = s.ctrl[B_STRIP] ? crc_n : 16'h0000; // [R7]
    body_raw = (s.wlen > cut_rec) ? s.wlen - cut_rec : 16'h0000;
    if (body_raw > {4'h0, s.snap}) body_raw = {4'h0, s.snap}; // [R23]
    body = s.ctrl[B_VARLEN] ? body_raw[12:0] : {1'b0, s.snap}; // [R23] [R24]
    wide = s.ctrl[B_WIDEALIGN] || s.ctrl[B_VARLEN]; // [R4]
    total = HDR_BYTES + body; // [R3]
    total = wide ? ((total + 13'h0007) & 13'h1FF8) : ((total + 13'h0003) & 13'h1FFC); // [R5]
    ready_ok = s.ctrl[B_DECOUPLE] ? stream_ready[s.tgt] : (&stream_ready); // [R11] [R12]

    // Capture and record emission.
    case (s.st)
      ST_IDLE:
      begin
        if (frm_rise && s.ctrl[B_CAPTURE])
        begin
          n.st = ST_CAP;
          n.wlen = 16'h0000;
        end
      end
      ST_CAP:
      begin
        if (lclk_rise && frm)
        begin
          // Only the first snap-length bytes are kept; the count keeps running.
          mem_we = (s.wlen < {4'h0, s.snap}); // [R23]
          if (s.wlen != 16'hFFFF) n.wlen = s.wlen + 16'h0001;
        end
        if (frm_fall)
        begin
          n.dlen = body_raw[11:0];
          n.rlen = total;
          n.rec_wlen = (s.wlen > cut_wlen) ? s.wlen - cut_wlen : 16'h0000; // [R7]
          n.err = {s.wlen < s.min_len, s.wlen > s.max_len}; // [R9] [R10]
          n.bcnt = 13'h0000;
          n.st = ST_EMIT;
          if (s.ctrl[B_DECOUPLE] && !stream_ready[s.tgt])
          begin
            // The busy stream loses this record; the other stream is not held up.
            n.st = ST_IDLE; // [R11]
            n.tgt = !s.tgt;
            if (s.drop_cnt != 16'hFFFF) n.drop_cnt = s.drop_cnt + 16'h0001; // [R25]
          end
        end
      end
      ST_EMIT:
      begin
        // A new frame while the record drains has nowhere to go and is lost at the port.
        if (frm_rise && s.drop_cnt != 16'hFFFF) n.drop_cnt = s.drop_cnt + 16'h0001; // [R12] [R25]
        if (!s.rec_valid || ready_ok)
        begin
          if (s.bcnt == s.rlen)
          begin
            n.rec_valid = 1'b0;
            n.rec_last = 1'b0;
            n.st = ST_IDLE;
            n.tgt = !s.tgt;
          end
          else
          begin
            n.rec_valid = 1'b1;
            n.rec_stream = s.tgt;
            n.rec_last = (s.bcnt == s.rlen - 13'h0001);
            n.bcnt = s.bcnt + 13'h0001;
            case (s.bcnt)
              13'h0000: n.rec_data = {3'h0, s.rlen[12:8]};
              13'h0001: n.rec_data = s.rlen[7:0];
              13'h0002: n.rec_data = s.rec_wlen[15:8];
              13'h0003: n.rec_data = s.rec_wlen[7:0];
              13'h0004: n.rec_data = {6'h00, s.err};
              13'h0005: n.rec_data = {7'h00, s.tgt};
              13'h0006, 13'h0007: n.rec_data = 8'h00;
              // Bytes past the stored data are padding for snap length and alignment.
              default: n.rec_data = (s.bcnt - HDR_BYTES < {1'b0, s.dlen}) ?
                                    cap_mem[12'(s.bcnt - HDR_BYTES)] : 8'h00; // [R3] [R24]
            endcase
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Transmit side: host loopback, line loopback, or paced transmit.
    if (tx_valid && !s.txh_full)
    begin
      if (s.ctrl[B_EQL])
      begin
        n.loop_valid = 1'b1; // [R13]
        n.loop_data = tx_data;
      end
      else if (!s.ctrl[B_FCL])
      begin
        n.txh_full = 1'b1;
        n.txh = tx_data;
      end
    end
    if (s.ctrl[B_FCL] && lclk_rise && frm)
    begin
      n.line_tx_valid = 1'b1; // [R14]
      n.line_tx_data = s.dat_s[2];
    end
    else if (s.txh_full && (s.ctrl[B_MASTER] ? ref_rise : lclk_rise)) // [R15]
    begin
      n.line_tx_valid = 1'b1;
      n.line_tx_data = s.txh;
      n.txh_full = 1'b0;
    end

    // Bus slave: reads take one wait state so a write just before is visible.
    n.hready = 1'b1;
    n.rd_pend = 1'b0;
    if (s.rd_pend)
    begin
      case (s.bus_addr)
        OFS_CTRL:   n.hrdata = {15'h0000, s.ctrl};
        OFS_SNAP:   n.hrdata = {20'h00000, s.snap};
        OFS_MINLEN: n.hrdata = {16'h0000, s.min_len};
        OFS_MAXLEN: n.hrdata = {16'h0000, s.max_len};
        OFS_MEMCFG: n.hrdata = {14'h0000, s.tx_streams, s.mem_total};
        OFS_DROP:   n.hrdata = {14'h0000, s.st, s.drop_cnt};
        OFS_ALLOC:  n.hrdata = {16'h0000, rx_alloc};
        default:    n.hrdata = 32'h00000000;
      endcase
    end
    if (hsel && htrans[1] && s.hready)
    begin
      n.bus_addr = haddr[7:0];
      n.wr_pend = hwrite;
      n.rd_pend = !hwrite;
      n.hready = hwrite;
    end

    // Write data phase; unmapped and read-only offsets ignore the data.
    soft_rst = 1'b0;
    if (s.wr_pend)
    begin
      case (s.bus_addr)
        OFS_CTRL:
        begin
          n.ctrl = hwdata[CTRL_W-1:0]; // [R16] [R17] [R18] [R22]
          soft_rst = hwdata[B_SOFTRST];
        end
        OFS_SNAP:   n.snap = {hwdata[11:3], 3'h0}; // [R1]
        OFS_MINLEN: n.min_len = hwdata[15:0];
        OFS_MAXLEN: n.max_len = hwdata[15:0];
        OFS_MEMCFG:
        begin
          if (!s.ctrl[B_CAPTURE]) // [R21]
          begin
            n.mem_total = hwdata[15:0];
            n.tx_streams = hwdata[B_MEMTX+:2];
          end
        end
        default: ;
      endcase
    end

    // Reset command: logic back to idle and drop counter cleared, settings kept.
    if (soft_rst)
    begin
      n.drop_cnt = 16'h0000; // [R19]
      n.st = ST_IDLE;
      n.rec_valid = 1'b0;
      n.rec_last = 1'b0;
      n.tgt = 1'b0;
      n.txh_full = 1'b0;
    end
  end

  // Receive memory per stream; transmit streams take a fixed share in combined mode.
  always_comb
  begin
    rx_alloc = s.mem_total;
    if (s.ctrl[B_RXTX])
      rx_alloc = (s.mem_total > TX_STREAM_MB * {14'h0000, s.tx_streams}) ?
                 s.mem_total - 16'(TX_STREAM_MB * {14'h0000, s.tx_streams}) : 16'h0000; // [R20]
    rx_alloc = rx_alloc >> RX_STREAMS_LOG2;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // The whole state registers here; the power-on value carries the defaults.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= ST_RST; // [R2]
    else
      s <= n;
  end

  // Capture memory has no reset; only bytes below the stored length are ever read.
  always_ff @(posedge hclk)
  begin
    if (mem_we)
      cap_mem[mem_wa] <= s.dat_s[2];
  end

  // Outputs come straight from state flops, except hresp, which is tied low, and tx_ready, which inverts txh_full.
  assign hreadyout = s.hready;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign line_tx_valid = s.line_tx_valid;
  assign line_tx_data = s.line_tx_data;
  assign tx_ready = !s.txh_full;
  assign loop_valid = s.loop_valid;
  assign loop_data = s.loop_data;
  assign rec_valid = s.rec_valid;
  assign rec_data = s.rec_data;
  assign rec_last = s.rec_last;
  assign rec_stream = s.rec_stream;
  assign laser_en = s.ctrl[B_LASER]; // [R22]
  assign frame_scramble_en = s.ctrl[B_FRAMESCR]; // [R16]
  assign payload_scramble_en = s.ctrl[B_PAYSCR]; // [R17]
  assign framer_atm = s.ctrl[B_ATM]; // [R18]
  assign framer_oc48 = s.ctrl[B_OC48]; // [R18]
  assign crc_mode = s.ctrl[B_CRCSEL+:2]; // [R6]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_wide_varlen: assert property (s.st == ST_EMIT && s.ctrl[B_VARLEN] |-> s.rlen[2:0] == 3'h0) // [R4]
    else $error("varlen record not 8-byte aligned");
  chk_align_min: assert property (s.st == ST_EMIT |-> s.rlen[1:0] == 2'h0) // [R5]
    else $error("record not 4-byte aligned");
  chk_trunc_snap: assert property (s.st == ST_EMIT |-> {4'h0, s.dlen} <= {4'h0, s.snap}) // [R23]
    else $error("stored data exceeds snap length");
  chk_fixed_pad: assert property (s.st == ST_EMIT && !s.ctrl[B_VARLEN] && !s.ctrl[B_WIDEALIGN]
                                  |-> s.rlen == HDR_BYTES + {1'b0, s.snap}) // [R24]
    else $error("fixed record not padded to snap");
  chk_len_flags: assert property (s.st == ST_CAP && frm_fall |=>
                                  s.err == {$past(s.wlen) < s.min_len, $past(s.wlen) > s.max_len}) // [R9] [R10]
    else $error("length flags wrong");
  chk_drop_sat: assert property (s.drop_cnt == 16'hFFFF && !soft_rst |=> s.drop_cnt == 16'hFFFF) // [R25]
    else $error("drop counter wrapped");
  chk_soft_reset: assert property (soft_rst |=> s.drop_cnt == 16'h0000 && s.st == ST_IDLE
                                   && s.snap == $past(s.snap)) // [R19]
    else $error("reset command misbehaved");
  chk_host_loop: assert property (tx_valid && tx_ready && s.ctrl[B_EQL] |=> loop_valid
                                  && loop_data == $past(tx_data) && !s.txh_full) // [R13]
    else $error("host loopback lost data");
  chk_laser_ctl: assert property (s.wr_pend && s.bus_addr == OFS_CTRL |=> laser_en == $past(hwdata[B_LASER])) // [R22]
    else $error("laser does not follow control");
  chk_coupled_hold: assert property (rec_valid && !s.ctrl[B_DECOUPLE] && !(&stream_ready) && !soft_rst
                                     |=> rec_valid && $stable(rec_data)) // [R12]
    else $error("coupled streams advanced without all ready");

  cov_record_done: cover property (rec_valid && rec_last && ready_ok);
  cov_stream_drop: cover property (s.st == ST_CAP && frm_fall && s.ctrl[B_DECOUPLE] && !stream_ready[s.tgt]);
  cov_line_loop: cover property (line_tx_valid && s.ctrl[B_FCL]);

endmodule

`default_nettype wire

// [tb/pcr_line_model.sv]
// Partner model of the optical line and the host memory streams.
`timescale 1ns/1ps
`default_nettype none

module pcr_line_model
(
  input  wire logic       hclk,
  input  wire logic       slow,
  input  wire logic       block,
  output logic            line_clk,
  output logic            line_frame,
  output logic [7:0]      line_data,
  output logic            ref_clk,
  output logic [1:0]      stream_ready
);
  logic [2:0] cnt_q = 3'h0;

  // Reference clock runs free; the recovered clock only runs inside frames.
  initial
  begin
    ref_clk = 1'b0;
    line_clk = 1'b0;
    line_frame = 1'b0;
    line_data = 8'h00;
    stream_ready = 2'h3;
  end
  always #30 ref_clk = ~ref_clk;

  // A slow host stalls each stream on its own pattern, so coupled mode has to wait for both.
  always @(posedge hclk)
  begin
    cnt_q <= cnt_q + 3'h1;
    stream_ready <= block ? 2'h0 : (slow ? cnt_q[2:1] : 2'h3);
  end

  // One framed packet; byte i is seed plus i, and the released line shows the inverse of the last byte.
  task automatic send_pkt(input int n, input logic [7:0] s);
    line_frame <= 1'b1;
    line_data <= s;
    #250;
    for (int i = 1; i <= n; i++)
    begin
      #62.5 line_clk <= 1'b1;
      #62.5 line_clk <= 1'b0;
      if (i < n)
        line_data <= s + 8'(i);
    end
    line_frame <= 1'b0;
    line_data <= ~(s + 8'(n - 1));
    #300;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the capture receive path against an integer record model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pcr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, slow, block, dec, tx_valid, hreadyout, hresp, line_clk, line_frame;
  logic        ref_clk, line_tx_valid, tx_ready, loop_valid, rec_valid, rec_last, rec_stream, laser_en;
  logic        frame_scramble_en, payload_scramble_en, framer_atm, framer_oc48;
  logic [31:0] haddr, hwdata, hrdata, q, rs;
  logic [1:0]  htrans, stream_ready, crc_mode;
  logic [2:0]  hsize;
  logic [7:0]  line_data, tx_data, line_tx_data, loop_data, rec_data, lb, lt;
  logic [7:0]  hb[9];
  int          n_errors, comparisons, nb, ntx, nrec;
  int          len_q[$], str_q[$];
  logic [31:0] hdr_q[$];
  localparam logic [31:0] CFG[8] = '{32'h6, 32'h0, 32'h28, 32'h52, 32'h42, 32'h2, 32'h200, 32'h2032};
  localparam int          LEN[8] = '{10, 30, 60, 40, 41, 9, 70, 44};

  pcr_rx_path DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .line_clk(line_clk), .line_frame(line_frame), .line_data(line_data), .ref_clk(ref_clk),
    .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .loop_valid(loop_valid), .loop_data(loop_data), .stream_ready(stream_ready),
    .rec_valid(rec_valid), .rec_data(rec_data), .rec_last(rec_last), .rec_stream(rec_stream),
    .laser_en(laser_en), .frame_scramble_en(frame_scramble_en), .payload_scramble_en(payload_scramble_en),
    .framer_atm(framer_atm), .framer_oc48(framer_oc48), .crc_mode(crc_mode));

  pcr_line_model LM (.hclk(hclk), .slow(slow), .block(block), .line_clk(line_clk), .line_frame(line_frame),
    .line_data(line_data), .ref_clk(ref_clk), .stream_ready(stream_ready));

  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  // Records are gathered at the falling edge, where handshake values are settled before the accepting edge.
  always @(negedge hclk)
  begin
    if (rec_valid && (dec ? stream_ready[rec_stream] : &stream_ready))
    begin
      if (nb < 9)
        hb[nb] = rec_data;
      nb++;
      if (rec_last)
      begin
        len_q.push_back(nb);
        hdr_q.push_back({hb[2], hb[3], hb[4], hb[8]});
        str_q.push_back(rec_stream);
        nb = 0;
      end
    end
    if (line_tx_valid)
    begin
      ntx++;
      lt = line_tx_data;
    end
    if (loop_valid)
      lb = loop_data;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Record length model: header, then data truncated or padded, then rounded to the alignment.
  function automatic int exp_len(logic [31:0] c, int n, int sn);
    int cut, d, al;
    cut = (c[13] || c[4:3] == 2'h0 || !(c[5] || c[6])) ? 0 : (c[4:3] == 2'h1 ? 2 : 4);
    d = (n - cut < sn) ? n - cut : sn;
    if (!c[1])
      d = sn;
    al = (c[1] || c[2]) ? 8 : 4;
    return ((8 + d + al - 1) / al) * al;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // The master samples ready where it is settled, then acts right after the rising edge.
  task automatic wait_rdy(output logic [31:0] r);
    @(negedge hclk);
    while (!hreadyout)
      @(negedge hclk);
    r = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(r);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(r);
  endtask

  task automatic send_tx(input logic [7:0] d);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(negedge hclk);
    while (!tx_ready)
      @(negedge hclk);
    @(posedge hclk);
    tx_valid <= 1'b0;
    repeat (40) @(posedge hclk);
  endtask

  task automatic run_pkt(input logic [31:0] c, input int n, input int sn);
    logic [7:0] s;
    int t, w;
    s = 8'(xs());
    w = n - ((c[5] && !c[13] && c[4:3] != 2'h0) ? (c[4:3] == 2'h1 ? 2 : 4) : 0);
    bus(1'b1, OFS_CTRL, c | 32'h1, q);
    ntx = 0;
    LM.send_pkt(n, s);
    // Realign to the clock so the next bus request starts right after an edge.
    @(posedge hclk);
    t = 0;
    while (len_q.size() == 0 && t < 4000)
    begin
      @(posedge hclk);
      t++;
    end
    chk(crc_mode, c[4:3]);
    if (len_q.size() == 0)
      chk(32'h0, 32'h1);
    else
    begin
      chk(len_q.pop_front(), exp_len(c, n, sn));
      chk(hdr_q.pop_front(), {16'(w), 6'h0, 1'(n < 16), 1'(n > 64), s});
      chk(str_q.pop_front(), nrec % 2);
      nrec++;
    end
    if (c[9])
      chk(ntx, n);
  endtask

  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under half of this span.
  initial
  begin
    #500000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    {hresetn, hsel, hwrite, tx_valid, slow, block, dec, haddr, hwdata, htrans, tx_data} = '0;
    hsize = 3'h2;
    rs = 32'd65225;
    nb = 0;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFS_SNAP, 32'h0, q);
    chk(q, 32'h30);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q, 32'(CTRL_RST));
    bus(1'b0, 8'h1C, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, OFS_MAXLEN, 32'h40, q);
    // Fixed table of modes, then random lengths against a larger snap with a stalling host.
    for (int i = 0; i < 8; i++)
      run_pkt(CFG[i], LEN[i], 48);
    bus(1'b1, OFS_SNAP, 32'h38, q);
    slow = 1'b1;
    for (int i = 0; i < 4; i++)
      run_pkt(32'h4, 1 + int'(xs() % 100), 56);
    slow = 1'b0;
    // Decoupled streams that cannot take the record drop it and count it; the reset command clears the count.
    dec = 1'b1;
    block = 1'b1;
    bus(1'b1, OFS_CTRL, 32'h83, q);
    LM.send_pkt(20, 8'h11);
    repeat (30) @(posedge hclk);
    bus(1'b0, OFS_DROP, 32'h0, q);
    chk(q[15:0], 32'h1);
    chk(len_q.size(), 32'h0);
    bus(1'b1, OFS_CTRL, 32'h20083, q);
    bus(1'b0, OFS_DROP, 32'h0, q);
    chk(q[15:0], 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q, 32'h83);
    dec = 1'b0;
    block = 1'b0;
    // Stream sizes change only with capture off.
    bus(1'b1, OFS_CTRL, 32'h10000, q);
    bus(1'b1, OFS_MEMCFG, 32'h10080, q);
    bus(1'b0, OFS_ALLOC, 32'h0, q);
    chk(q, 32'd56);
    // Control outputs are read one edge after the write lands, so the new flop values are settled.
    bus(1'b1, OFS_CTRL, 32'h0E000, q);
    @(posedge hclk);
    chk({laser_en, framer_atm, framer_oc48, frame_scramble_en, payload_scramble_en}, 5'h1C);
    bus(1'b1, OFS_CTRL, 32'h01800, q);
    @(posedge hclk);
    chk({laser_en, framer_atm, framer_oc48, frame_scramble_en, payload_scramble_en}, 5'h03);
    bus(1'b1, OFS_CTRL, 32'h100, q);
    send_tx(8'h5A);
    chk(lb, 8'h5A);
    bus(1'b1, OFS_CTRL, 32'h400, q);
    send_tx(8'h3C);
    chk(lt, 8'h3C);
    // Slave mode holds the byte while the recovered clock is still, then sends it on the first line edge.
    bus(1'b1, OFS_CTRL, 32'h0, q);
    send_tx(8'h96);
    chk(tx_ready, 32'h0);
    LM.send_pkt(2, 8'h00);
    chk(lt, 8'h96);
    end_sim();
  end
endmodule
`default_nettype wire
